/* File: include/psc_pkg.sv */
// Constants and types for the processor sideband control block.
// Assumes one bus clock; pins other than the local interrupt lines active low outside, active high inside.
package psc_pkg;
	// Synchroniser depth and field positions of the synchronised vector
	localparam int PSC_SYNC_STAGES = 3;
	localparam int PSC_SY_W        = 5;
	localparam int PSC_SY_FLUSH    = 0;
	localparam int PSC_SY_IGNORE_NUMERIC_ERROR_IN    = 1;
	localparam int PSC_SY_INIT     = 2;
	localparam int PSC_SY_LINT0    = 3;
	localparam int PSC_SY_LINT1    = 4;
	localparam logic [PSC_SY_W-1:0] PSC_SY_RST = 5'h00;
	// Local interrupt lines
	localparam int PSC_LINT_W    = 2;
	localparam int PSC_INTR_BIT  = 0;
	localparam int PSC_NMI_BIT   = 1;
	// Reset values
	localparam logic PSC_LIC_EN_RST = 1'b1;
	// Cycles after reset release until straps have crossed the synchroniser
	localparam int PSC_CFG_W = 3;
	localparam logic [PSC_CFG_W-1:0] PSC_CFG_WAIT = 3'h4;
	// Flush sequence
	typedef enum logic [2:0] {
		PSC_FL_IDLE,
		PSC_FL_WB,
		PSC_FL_INV,
		PSC_FL_ACK,
		PSC_FL_HOLD
	} psc_flush_t;
endpackage : psc_pkg

/* File: include/psc_flush_if.sv */
// Handshake bundle between the sideband top and its flush sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface psc_flush_if;
	logic flush_lvl;
	logic wb_req;
	logic wb_done;
	logic inv_req;
	logic inv_done;
	logic ack_req;
	logic ack_done;
	logic busy;
	modport seq (
		input  flush_lvl, wb_done, inv_done, ack_done,
		output wb_req, inv_req, ack_req, busy
	);
	modport ctl (
		output flush_lvl, wb_done, inv_done, ack_done,
		input  wb_req, inv_req, ack_req, busy
	);
endinterface : psc_flush_if

/* File: logic/psc_sync.sv */
// Three-stage synchroniser with agreement filter, one lane per bit.
// Assumes inputs are asynchronous levels; output moves when stages 2 and 3 agree.
`timescale 1ns/10ps
module psc_sync import psc_pkg::*; #(
	parameter int             W   = PSC_SY_W,
	parameter logic [W-1:0]   RST = '0
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// Levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_lane
			logic s1_ff;
			logic s2_ff;
			logic s3_ff;
			// Stage one feeds stage two only, to keep metastability contained
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					s1_ff          <= RST[i];
					s2_ff          <= RST[i];
					s3_ff          <= RST[i];
					sync_out[i]    <= RST[i];
				end else begin
					s1_ff <= async_in[i];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
					if (s2_ff == s3_ff) begin
						sync_out[i] <= s3_ff;
					end
				end
			end
		end
	endgenerate
endmodule : psc_sync

/* File: logic/psc_flush.sv */
// Cache flush sequencer: write back, invalidate, then acknowledge on the bus.
// Assumes cache and bus controllers answer each request with a done pulse.
`timescale 1ns/10ps
module psc_flush import psc_pkg::*; (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// Sequencer side
	psc_flush_if.seq  fi
);
	psc_flush_t st_ff;
	psc_flush_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			PSC_FL_IDLE: if (fi.flush_lvl) nxt_st = PSC_FL_WB;
			PSC_FL_WB:   if (fi.wb_done) nxt_st = PSC_FL_INV;
			PSC_FL_INV:  if (fi.inv_done) nxt_st = PSC_FL_ACK;
			PSC_FL_ACK:  if (fi.ack_done) nxt_st = PSC_FL_HOLD;
			// One flush per assertion of the pin
			PSC_FL_HOLD: if (!fi.flush_lvl) nxt_st = PSC_FL_IDLE;
			default:     nxt_st = PSC_FL_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_ff <= PSC_FL_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign fi.wb_req  = (st_ff == PSC_FL_WB);
	assign fi.inv_req = (st_ff == PSC_FL_INV);
	assign fi.ack_req = (st_ff == PSC_FL_ACK);
	assign fi.busy    = (st_ff != PSC_FL_IDLE);

	a_flush_order: assert property (@(posedge clk) disable iff (!reset_n)
		fi.ack_req |-> $past(st_ff) inside {PSC_FL_INV, PSC_FL_ACK})
		else $error("flush acknowledge before invalidation");
endmodule : psc_flush

/* File: logic/psc_sideband_top.sv */
// Sideband control of the processor: error pins, flush, snoop result drive,
// soft init, power-on straps and local interrupt line fallback.
// Assumes the bus clock is clk; all pins active low except the local interrupt lines; open-drain snoop pins.
`timescale 1ns/10ps
// Notes on behaviour
// - Unmasked floating-point error drives error pin
// - Flush writes back modified lines, then invalidates
// - Flush acknowledge issued after invalidation completes
// - No cache allocation while flush stays asserted
// - Flush sampled at reset release for configuration
// - Both snoop lines together request or extend stall
// - Internal error drives pin, requests shutdown
// - Internal error held until reset or init
// - Ignore input masks pending numeric error
// - Without ignore, next noncontrol instruction faults
// - Ignore input has no effect when enable set
// - Soft init resets integer state only
// - Snoops still serviced during soft init
// - Soft init at reset release runs self-test
// - Controller off: lines become maskable, nonmaskable
// - Local interrupt controller enabled after reset
module psc_sideband_top import psc_pkg::*; (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  reset_n,
	// Asynchronous pins
	input  wire logic                  flush_in_n,
	input  wire logic                  ignore_numeric_error_in_n,
	input  wire logic                  soft_init_in_n,
	input  wire logic [PSC_LINT_W-1:0] local_irq_in,
	// Bus clock pins
	input  wire logic                  bus_init_in_n,
	input  wire logic                  snoop_hit_in_n,
	output logic                       snoop_hit_out_n,
	output logic                       snoop_hit_oe_n,
	input  wire logic                  snoop_hit_modified_in_n,
	output logic                       snoop_hit_modified_out_n,
	output logic                       snoop_hit_modified_oe_n,
	// Error pins
	output logic                       fp_error_out_n,
	output logic                       internal_error_out_n,
	// Floating-point unit
	input  wire logic                  fp_err_unmasked,
	input  wire logic                  fp_err_clear,
	input  wire logic                  fp_noncontrol_issue,
	input  wire logic                  numeric_error_enable,
	output logic                       fp_exception,
	// Internal error and shutdown
	input  wire logic                  internal_error_event,
	output logic                       shutdown_req,
	// Cache controller
	output logic                       wb_all_req,
	input  wire logic                  wb_all_done,
	output logic                       inval_all_req,
	input  wire logic                  inval_all_done,
	output logic                       alloc_inhibit,
	// Bus transaction unit
	output logic                       flush_ack_req,
	input  wire logic                  flush_ack_done,
	// Snoop unit
	input  wire logic                  snoop_phase,
	input  wire logic                  snoop_hit_res,
	input  wire logic                  snoop_snoop_hit_modified_res,
	input  wire logic                  snoop_busy,
	output logic                       snoop_stall_seen,
	// Soft init and configuration
	output logic                       int_reg_reset,
	output logic                       bist_run,
	output logic                       cfg_done,
	output logic                       cfg_flush_strap,
	// Local interrupt controller
	input  wire logic                  lic_cfg_wr,
	input  wire logic                  lic_cfg_en,
	output logic                       local_interrupt_controller_en,
	output logic [PSC_LINT_W-1:0]      lint_to_lic,
	output logic                       intr_req,
	output logic                       nmi_pulse
);
	logic [PSC_SY_W-1:0]  raw_in;
	logic [PSC_SY_W-1:0]  sy;
	logic [PSC_CFG_W-1:0] cfg_cnt_ff;
	logic                 cfg_done_ff;
	logic                 strap_flush_ff;
	logic                 bist_ff;
	logic                 init_d_ff;
	logic                 init_pulse_ff;
	logic                 fp_pend_ff;
	logic                 fp_exc_ff;
	logic                 internal_error_out_ff;
	logic                 shut_ff;
	logic                 hit_drv_ff;
	logic                 snoop_hit_modified_drv_ff;
	logic                 stall_ff;
	logic                 lic_en_ff;
	logic [PSC_LINT_W-1:0] lint_ff;
	logic                 intr_ff;
	logic                 l1_d_ff;
	logic                 nmi_ff;
	logic                 inhibit_ff;
	logic                 init_lvl;
	logic                 flush_lvl;
	logic                 fp_take;

	psc_flush_if fi ();

	// Control pins are active low, interrupt lines active high; the synchroniser works on active-high levels
	assign raw_in = {local_irq_in, ~soft_init_in_n, ~ignore_numeric_error_in_n, ~flush_in_n};

	psc_sync #(
		.W   (PSC_SY_W),
		.RST (PSC_SY_RST)
	) u_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in (raw_in),
		.sync_out (sy)
	);

	// Straps and actions wait until the synchroniser holds real pin levels
	assign init_lvl  = sy[PSC_SY_INIT] & cfg_done_ff;
	assign flush_lvl = sy[PSC_SY_FLUSH] & cfg_done_ff;

	// Power-on configuration capture
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_cnt_ff     <= '0;
			cfg_done_ff    <= 1'b0;
			strap_flush_ff <= 1'b0;
			bist_ff        <= 1'b0;
		end else begin
			bist_ff <= 1'b0;
			if (!cfg_done_ff) begin
				cfg_cnt_ff <= cfg_cnt_ff + 3'h1;
				if (cfg_cnt_ff == PSC_CFG_WAIT) begin
					cfg_done_ff    <= 1'b1;
					strap_flush_ff <= sy[PSC_SY_FLUSH];
					bist_ff        <= sy[PSC_SY_INIT];
				end
			end
		end
	end

	// Soft init: one pulse per assertion; caches and fp state are left alone
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			init_d_ff     <= 1'b0;
			init_pulse_ff <= 1'b0;
		end else begin
			init_d_ff     <= init_lvl;
			init_pulse_ff <= init_lvl & ~init_d_ff;
		end
	end

	// Numeric error tracking
	assign fp_take = fp_noncontrol_issue & fp_pend_ff
		& (numeric_error_enable | ~sy[PSC_SY_IGNORE_NUMERIC_ERROR_IN]);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fp_pend_ff <= 1'b0;
			fp_exc_ff  <= 1'b0;
		end else begin
			// A new error in the clearing cycle is kept
			if (fp_err_unmasked) begin
				fp_pend_ff <= 1'b1;
			end else if (fp_err_clear) begin
				fp_pend_ff <= 1'b0;
			end
			fp_exc_ff <= fp_take;
		end
	end

	// Internal error latch
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			internal_error_out_ff <= 1'b0;
			shut_ff <= 1'b0;
		end else begin
			if (internal_error_event) begin
				internal_error_out_ff <= 1'b1;
			end else if (~bus_init_in_n | init_lvl) begin
				internal_error_out_ff <= 1'b0;
			end
			shut_ff <= internal_error_event & ~internal_error_out_ff;
		end
	end

	// Snoop result drive; not gated by soft init so snoops keep going
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hit_drv_ff  <= 1'b0;
			snoop_hit_modified_drv_ff <= 1'b0;
			stall_ff    <= 1'b0;
		end else begin
			if (snoop_phase) begin
				// Busy snooper drives both lines, again each phase to extend
				hit_drv_ff  <= snoop_busy | snoop_hit_res;
				snoop_hit_modified_drv_ff <= snoop_busy | snoop_snoop_hit_modified_res;
			end else begin
				hit_drv_ff  <= 1'b0;
				snoop_hit_modified_drv_ff <= 1'b0;
			end
			stall_ff <= snoop_phase & ~snoop_hit_in_n & ~snoop_hit_modified_in_n;
		end
	end

	// Local interrupt controller enable and line routing
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lic_en_ff <= PSC_LIC_EN_RST;
		end else if (lic_cfg_wr) begin
			lic_en_ff <= lic_cfg_en;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lint_ff <= '0;
			intr_ff <= 1'b0;
			l1_d_ff <= 1'b0;
			nmi_ff  <= 1'b0;
		end else begin
			lint_ff <= lic_en_ff ? sy[PSC_SY_LINT1:PSC_SY_LINT0] : '0;
			intr_ff <= ~lic_en_ff & sy[PSC_SY_LINT0];
			l1_d_ff <= sy[PSC_SY_LINT1];
			// Nonmaskable interrupt is edge triggered
			nmi_ff  <= ~lic_en_ff & sy[PSC_SY_LINT1] & ~l1_d_ff;
		end
	end

	// Flush hookup; allocation blocked for the whole pin assertion
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			inhibit_ff <= 1'b0;
		end else begin
			inhibit_ff <= flush_lvl;
		end
	end

	assign fi.flush_lvl = flush_lvl;
	assign fi.wb_done   = wb_all_done;
	assign fi.inv_done  = inval_all_done;
	assign fi.ack_done  = flush_ack_done;

	psc_flush u_flush (
		.clk     (clk),
		.reset_n (reset_n),
		.fi      (fi.seq)
	);

	// Outputs
	assign wb_all_req                    = fi.wb_req;
	assign inval_all_req                 = fi.inv_req;
	assign flush_ack_req                 = fi.ack_req;
	assign alloc_inhibit                 = inhibit_ff | fi.busy;
	assign fp_error_out_n                = ~fp_pend_ff;
	assign fp_exception                  = fp_exc_ff;
	assign internal_error_out_n          = ~internal_error_out_ff;
	assign shutdown_req                  = shut_ff;
	assign snoop_hit_out_n               = ~hit_drv_ff;
	assign snoop_hit_oe_n                = ~hit_drv_ff;
	assign snoop_hit_modified_out_n      = ~snoop_hit_modified_drv_ff;
	assign snoop_hit_modified_oe_n       = ~snoop_hit_modified_drv_ff;
	assign snoop_stall_seen              = stall_ff;
	assign int_reg_reset                 = init_pulse_ff;
	assign bist_run                      = bist_ff;
	assign cfg_done                      = cfg_done_ff;
	assign cfg_flush_strap               = strap_flush_ff;
	assign local_interrupt_controller_en = lic_en_ff;
	assign lint_to_lic                   = lint_ff;
	assign intr_req                      = intr_ff;
	assign nmi_pulse                     = nmi_ff;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_wb_done;
		wb_all_req && wb_all_done;
	endsequence
	sequence s_inv_next;
		##1 inval_all_req;
	endsequence

	a_fp_err_pin: assert property (
		fp_err_unmasked |=> !fp_error_out_n)
		else $error("fp error pin not asserted");
	a_flush_wb_inv: assert property (
		s_wb_done |-> s_inv_next)
		else $error("invalidate did not follow write back");
	a_flush_ack_step: assert property (
		inval_all_req && inval_all_done |=> flush_ack_req)
		else $error("flush acknowledge missing");
	a_flush_inhibit: assert property (
		$rose(flush_lvl) |=> alloc_inhibit [*2])
		else $error("allocation not inhibited during flush");
	a_snoop_stall: assert property (
		snoop_phase && snoop_busy |=> !snoop_hit_oe_n && !snoop_hit_modified_oe_n)
		else $error("stall not driven on both snoop lines");
	a_internal_error_out_hold: assert property (
		!internal_error_out_n && bus_init_in_n && !init_lvl |=> !internal_error_out_n)
		else $error("internal error released early");
	a_ignore_numeric_error_in_mask: assert property (
		!numeric_error_enable && sy[PSC_SY_IGNORE_NUMERIC_ERROR_IN] |=> !fp_exception)
		else $error("exception raised while ignored");
	a_ne_override: assert property (
		numeric_error_enable && fp_noncontrol_issue && fp_pend_ff |=> fp_exception)
		else $error("exception lost with enable set");
	a_lic_nmi: assert property (
		lic_en_ff |=> !nmi_pulse && !intr_req)
		else $error("fallback lines active with controller on");
	a_init_pulse: assert property (
		int_reg_reset |=> !int_reg_reset)
		else $error("soft init pulse longer than one cycle");

	sequence s_cfg_capture;
		!cfg_done_ff && cfg_cnt_ff == PSC_CFG_WAIT;
	endsequence

	a_shutdown_once: assert property (
		internal_error_event && !internal_error_out_ff |=> shutdown_req)
		else $error("shutdown request missing on first internal error");
	a_internal_error_out_set: assert property (
		internal_error_event |=> !internal_error_out_n)
		else $error("internal error pin not asserted");
	a_internal_error_out_clear: assert property (
		!bus_init_in_n && !internal_error_event |=> internal_error_out_n)
		else $error("internal error not cleared by bus init");
	a_ignore_numeric_error_in_off: assert property (
		fp_noncontrol_issue && fp_pend_ff && !sy[PSC_SY_IGNORE_NUMERIC_ERROR_IN] |=> fp_exception)
		else $error("exception missing with ignore inactive");
	a_init_edge: assert property (
		init_lvl && !init_d_ff |=> int_reg_reset)
		else $error("soft init pulse missing");
	a_snoop_init: assert property (
		init_lvl && snoop_phase && snoop_hit_res |=> !snoop_hit_oe_n)
		else $error("snoop result blocked during soft init");
	a_strap_flush: assert property (
		s_cfg_capture |=> cfg_done && cfg_flush_strap == $past(sy[PSC_SY_FLUSH]))
		else $error("flush strap not captured");
	a_strap_bist: assert property (
		s_cfg_capture |=> bist_run == $past(sy[PSC_SY_INIT]))
		else $error("self-test selection not captured");
	a_lint_route: assert property (
		lic_en_ff |=> lint_to_lic == $past(sy[PSC_SY_LINT1:PSC_SY_LINT0]))
		else $error("lines not routed to controller");
	a_intr_route: assert property (
		!lic_en_ff |=> intr_req == $past(sy[PSC_SY_LINT0]))
		else $error("maskable request does not follow line zero");
	// Both agreeing samples must have seen the pin active
	a_sync_flush: assert property (
		$rose(sy[PSC_SY_FLUSH])
			|-> $past(raw_in[PSC_SY_FLUSH], 3) && $past(raw_in[PSC_SY_FLUSH], 4))
		else $error("flush level passed without synchronisation");
endmodule : psc_sideband_top

/* File: tb/psc_far_model.sv */
// Far side: cache and bus units answering with done pulses, plus a second snoop agent.
// Assumes the block's bus clock; snoop wires carry pull-ups.
`timescale 1ns/10ps
module psc_far_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// Requests and their done pulses
	input  wire logic [2:0] req,
	input  wire logic       slow,
	output logic      [2:0] done,
	// Snoop wires
	input  wire logic       stall,
	input  wire logic [1:0] dut_oe_n,
	input  wire logic [1:0] dut_out_n,
	output logic      [1:0] wire_n
);
	logic [2:0]      served_ff;
	logic [2:0][3:0] cnt_ff;

	// One pulse per request; served flag stops a second pulse before req drops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			done      <= 3'h0;
			served_ff <= 3'h0;
			cnt_ff    <= '0;
		end else begin
			for (int k = 0; k < 3; k++) begin
				done[k] <= 1'b0;
				if (!req[k]) begin
					served_ff[k] <= 1'b0;
					cnt_ff[k]    <= 4'h0;
				end else if (!served_ff[k]) begin
					if (cnt_ff[k] >= (slow ? 4'h6 : 4'h1)) begin
						done[k]      <= 1'b1;
						served_ff[k] <= 1'b1;
					end else begin
						cnt_ff[k] <= cnt_ff[k] + 4'h1;
					end
				end
			end
		end
	end

	// Pulled up; low while either agent drives low
	assign wire_n = (dut_oe_n | dut_out_n) & {2{~stall}};
endmodule : psc_far_model

/* File: tb/tb.sv */
// Self-checking bench for the processor sideband control top.
// Assumes a 50 MHz bus clock and the far-side model for done pulses and snoop wires.
`timescale 1ns/10ps
module tb import psc_pkg::*;;
	logic clk, reset_n, flush_in_n, ignore_numeric_error_in_n, soft_init_in_n, bus_init_in_n;
	logic [PSC_LINT_W-1:0] local_irq_in, lint_to_lic;
	logic snoop_hit_out_n, snoop_hit_oe_n, snoop_hit_modified_out_n, snoop_hit_modified_oe_n;
	logic fp_error_out_n, internal_error_out_n, fp_err_unmasked, fp_err_clear;
	logic fp_noncontrol_issue, numeric_error_enable, fp_exception, internal_error_event;
	logic shutdown_req, wb_all_req, wb_all_done, inval_all_req, inval_all_done, alloc_inhibit;
	logic flush_ack_req, flush_ack_done, snoop_phase, snoop_hit_res, snoop_snoop_hit_modified_res;
	logic snoop_busy, snoop_stall_seen, int_reg_reset, bist_run, cfg_done, cfg_flush_strap;
	logic lic_cfg_wr, lic_cfg_en, local_interrupt_controller_en, intr_req, nmi_pulse;
	logic far_slow, far_stall;
	logic [2:0] far_done;
	logic [1:0] wire_n;
	int fails, samples_checked, cycles, bist_seen, nmi_seen, irr_seen;

	psc_sideband_top u_dut (.clk, .reset_n, .flush_in_n, .ignore_numeric_error_in_n,
		.soft_init_in_n, .local_irq_in, .bus_init_in_n, .snoop_hit_in_n(wire_n[0]),
		.snoop_hit_out_n, .snoop_hit_oe_n, .snoop_hit_modified_in_n(wire_n[1]),
		.snoop_hit_modified_out_n, .snoop_hit_modified_oe_n, .fp_error_out_n,
		.internal_error_out_n, .fp_err_unmasked, .fp_err_clear, .fp_noncontrol_issue,
		.numeric_error_enable, .fp_exception, .internal_error_event, .shutdown_req,
		.wb_all_req, .wb_all_done, .inval_all_req, .inval_all_done, .alloc_inhibit,
		.flush_ack_req, .flush_ack_done, .snoop_phase, .snoop_hit_res, .snoop_snoop_hit_modified_res,
		.snoop_busy, .snoop_stall_seen, .int_reg_reset, .bist_run, .cfg_done,
		.cfg_flush_strap, .lic_cfg_wr, .lic_cfg_en, .local_interrupt_controller_en,
		.lint_to_lic, .intr_req, .nmi_pulse);

	psc_far_model u_far (.clk, .reset_n, .req({flush_ack_req, inval_all_req, wb_all_req}),
		.slow(far_slow), .done(far_done), .stall(far_stall),
		.dut_oe_n({snoop_hit_modified_oe_n, snoop_hit_oe_n}),
		.dut_out_n({snoop_hit_modified_out_n, snoop_hit_out_n}), .wire_n(wire_n));

	assign wb_all_done    = far_done[0];
	assign inval_all_done = far_done[1];
	assign flush_ack_done = far_done[2];

	always #10 clk = ~clk;

	// Pulse counters and hang guard
	always @(posedge clk) begin
		cycles++;
		if (bist_run === 1'b1) bist_seen++;
		if (nmi_pulse === 1'b1) nmi_seen++;
		if (int_reg_reset === 1'b1) irr_seen++;
		if (cycles == 3000) begin
			fails++;
			report_and_stop();
		end
	end

	task automatic tick;
		@(posedge clk);
		#2;
	endtask : tick

	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic do_reset(input logic fl_n, input logic in_n);
		reset_n = 1'b0;
		flush_in_n = fl_n;
		soft_init_in_n = in_n;
		bist_seen = 0;
		repeat (8) tick();
		chk(local_interrupt_controller_en, 1'b1);
		chk({fp_error_out_n, internal_error_out_n, snoop_hit_oe_n, snoop_hit_modified_oe_n}, 4'hf);
		reset_n = 1'b1;
		for (int i = 0; i < 10 && cfg_done !== 1'b1; i++) tick();
		tick();
		chk({cfg_done, cfg_flush_strap}, {2'h0, 1'b1, ~fl_n});
		chk(bist_seen[3:0], {3'h0, ~in_n});
		flush_in_n = 1'b1;
		soft_init_in_n = 1'b1;
		// A strap-held flush runs to its end before the next scenario
		repeat (40) tick();
		chk({wb_all_req, alloc_inhibit}, 2'h0);
	endtask : do_reset

	task automatic t_flush(input logic slow);
		far_slow = slow;
		flush_in_n = 1'b0;
		repeat (2) tick();
		chk(wb_all_req, 1'b0);
		for (int i = 0; i < 20 && wb_all_req !== 1'b1; i++) tick();
		chk({wb_all_req, inval_all_req, flush_ack_req, alloc_inhibit}, 4'h9);
		for (int i = 0; i < 20 && inval_all_req !== 1'b1; i++) tick();
		chk({wb_all_req, inval_all_req, flush_ack_req}, 3'h2);
		for (int i = 0; i < 20 && flush_ack_req !== 1'b1; i++) tick();
		chk({inval_all_req, flush_ack_req}, 2'h1);
		repeat (12) tick();
		chk({wb_all_req, flush_ack_req, alloc_inhibit}, 3'h1);
		flush_in_n = 1'b1;
		repeat (8) tick();
		chk(alloc_inhibit, 1'b0);
	endtask : t_flush

	task automatic fp_issue(input logic exp);
		logic got;
		fp_noncontrol_issue = 1'b1;
		tick();
		fp_noncontrol_issue = 1'b0;
		got = fp_exception;
		tick();
		got = got | fp_exception;
		chk(got, exp);
	endtask : fp_issue

	task automatic t_fp;
		fp_err_unmasked = 1'b1;
		tick();
		fp_err_unmasked = 1'b0;
		chk(fp_error_out_n, 1'b0);
		ignore_numeric_error_in_n = 1'b0;
		repeat (6) tick();
		fp_issue(1'b0);
		numeric_error_enable = 1'b1;
		fp_issue(1'b1);
		numeric_error_enable = 1'b0;
		ignore_numeric_error_in_n = 1'b1;
		repeat (6) tick();
		fp_issue(1'b1);
		chk(fp_error_out_n, 1'b0);
		fp_err_clear = 1'b1;
		tick();
		fp_err_clear = 1'b0;
		tick();
		chk(fp_error_out_n, 1'b1);
	endtask : t_fp

	task automatic snoop(input logic busy, hit, snoop_hit_modified, st, input logic [2:0] exp);
		snoop_phase = 1'b1;
		snoop_busy = busy;
		snoop_hit_res = hit;
		snoop_snoop_hit_modified_res = snoop_hit_modified;
		far_stall = st;
		tick();
		// Phase stays up between back-to-back calls; the caller drops it
		chk({snoop_hit_oe_n, snoop_hit_modified_oe_n, snoop_stall_seen}, exp);
		chk({snoop_hit_out_n, snoop_hit_modified_out_n}, {2'h0, exp[2:1]});
	endtask : snoop

	task automatic t_internal_error_out_init;
		internal_error_event = 1'b1;
		tick();
		internal_error_event = 1'b0;
		chk({internal_error_out_n, shutdown_req}, 2'h1);
		repeat (10) tick();
		chk(internal_error_out_n, 1'b0);
		bus_init_in_n = 1'b0;
		tick();
		bus_init_in_n = 1'b1;
		tick();
		chk(internal_error_out_n, 1'b1);
		internal_error_event = 1'b1;
		tick();
		internal_error_event = 1'b0;
		irr_seen = 0;
		soft_init_in_n = 1'b0;
		repeat (8) tick();
		chk(internal_error_out_n, 1'b1);
		chk(irr_seen[3:0], 4'h1);
		snoop(1'b0, 1'b0, 1'b0, 1'b0, 3'h6);
		snoop(1'b0, 1'b1, 1'b0, 1'b0, 3'h2);
		snoop(1'b0, 1'b0, 1'b1, 1'b0, 3'h4);
		snoop(1'b1, 1'b0, 1'b0, 1'b0, 3'h0);
		snoop(1'b1, 1'b0, 1'b0, 1'b0, 3'h1);
		snoop(1'b0, 1'b0, 1'b0, 1'b1, 3'h7);
		snoop(1'b0, 1'b0, 1'b0, 1'b0, 3'h6);
		snoop_phase = 1'b0;
		far_stall = 1'b0;
		soft_init_in_n = 1'b1;
		repeat (6) tick();
	endtask : t_internal_error_out_init

	task automatic lic_write(input logic en);
		lic_cfg_en = en;
		lic_cfg_wr = 1'b1;
		tick();
		lic_cfg_wr = 1'b0;
		repeat (2) tick();
	endtask : lic_write

	task automatic t_lint;
		local_irq_in = 2'h1;
		repeat (7) tick();
		chk({lint_to_lic, intr_req}, 3'h2);
		lic_write(1'b0);
		chk({local_interrupt_controller_en, lint_to_lic, intr_req}, 4'h1);
		nmi_seen = 0;
		local_irq_in = 2'h3;
		repeat (7) tick();
		chk(nmi_seen[3:0], 4'h1);
		local_irq_in = 2'h2;
		repeat (7) tick();
		chk(intr_req, 1'b0);
		local_irq_in = 2'h0;
		lic_write(1'b1);
		chk(local_interrupt_controller_en, 1'b1);
	endtask : t_lint

	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		{clk, reset_n, local_irq_in, fp_err_unmasked, fp_err_clear} = '0;
		{fp_noncontrol_issue, numeric_error_enable, internal_error_event} = '0;
		{snoop_phase, snoop_hit_res, snoop_snoop_hit_modified_res, snoop_busy, lic_cfg_wr} = '0;
		{far_slow, far_stall} = '0;
		{flush_in_n, ignore_numeric_error_in_n, soft_init_in_n, bus_init_in_n, lic_cfg_en} = '1;
		{fails, samples_checked, cycles, bist_seen, nmi_seen, irr_seen} = '0;
		do_reset(1'b1, 1'b1);
		t_flush(1'b0);
		t_flush(1'b1);
		t_fp();
		t_internal_error_out_init();
		t_lint();
		do_reset(1'b0, 1'b0);
		report_and_stop();
	end
endmodule : tb
